// ==== hdl/idle_mode_wakeup_gating.sv ====
// Idle standby gate: entry, wake decision and peripheral clock gating.
`include "idle_map.svh"
module idle_mode_wakeup_gating
    import idle_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic reset_n,
    input wire logic second_watchdog_reset,
    // Register port.
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    // Wake requests from pins and the interrupt controller.
    input wire wake_in_t wake_in,
    input wire logic intc_take,
    input wire logic intc_discard,
    // Answers to the CPU and interrupt controller.
    output wake_out_t wake_out,
    // Clock gates and hold controls.
    output clk_en_t clk_en,
    output logic idle,
    output logic port_hold,
    output logic reg_hold,
    output logic dac_value_write_en,
    output logic rto_buffer_write_en
);

    typedef struct packed {
        idle_state_t st;
        logic standby_request_bit;
        logic maskable_wake_mask;
        logic pin_nmi_wake_mask;
        logic wdt_nmi_wake_mask;
        logic stop_select_bit;
        logic [15:0] clksel;
        logic wake_pend;
        logic ack_nmi;
        logic ack_maskable;
        logic resume_next;
        logic [15:0] rdata;
    } state_t;

    state_t s;
    state_t next_s;

    logic sys_reset;
    logic sub_used;
    logic nmi_wake;
    logic maskable_wake;
    logic wake_any;
    logic low_prio;
    logic tm1_runs;
    logic [1:0] tm5_runs;
    clk_en_t idle_en;

    // A watchdog reset is taken like the pin reset, so the same sequence
    // follows whether or not the block was idle.
    assign sys_reset = !reset_n || second_watchdog_reset;

    assign sub_used = s.clksel[`CS_SUB_USED];

    // Wake sources after the power-save masks.
    always_comb begin
        nmi_wake = (wake_in.nmi_pin && !s.pin_nmi_wake_mask)
            || (wake_in.second_watchdog_irq && !s.wdt_nmi_wake_mask
            && s.clksel[`CS_CPU_ON_SUB]);
        maskable_wake = !s.maskable_wake_mask
            && ((|(wake_in.external_irq_pins
            & wake_in.external_irq_enable))
            || wake_in.periph_irq);
        wake_any = nmi_wake || maskable_wake;
        // Smaller number is more urgent; equal counts as not higher.
        low_prio = wake_in.in_isr
            && (wake_in.req_prio >= wake_in.isr_prio);
    end

    // Clocks that survive idle.
    always_comb begin
        tm1_runs = s.clksel[`CS_TM1_WT]
            && (sub_used || s.clksel[`CS_WT_MAIN]);
        tm5_runs = s.clksel[`CS_TM5_EXT+1:`CS_TM5_EXT]
            | (s.clksel[`CS_TM5_CMP+1:`CS_TM5_CMP]
            & {2{sub_used}});
        idle_en = '0;
        idle_en.wide_timer = {2'b00, tm1_runs, 1'b0};
        idle_en.narrow_timer = tm5_runs;
        idle_en.second_interval_timer = sub_used
            && s.clksel[`CS_IH1_SUB];
        idle_en.second_watchdog = sub_used
            && s.clksel[`CS_WDT2_SUB];
        idle_en.watch_timer = sub_used
            || s.clksel[`CS_WT_MAIN];
        idle_en.csi = s.clksel[`CS_CSI_EXT+1:`CS_CSI_EXT];
        idle_en.uart = {2'b00, s.clksel[`CS_UART0_EXT]};
        idle_en.dac = 1'b1;
        idle_en.rto = s.clksel[`CS_RTO_EN]
            && tm5_runs[s.clksel[`CS_RTO_SEL]];
    end

    always_comb begin
        next_s = s;
        next_s.ack_nmi = 1'b0;
        next_s.ack_maskable = 1'b0;
        next_s.resume_next = 1'b0;
        next_s.rdata = 16'h0000;
        // Reads answer in the following cycle only.
        if (rd) begin
            if (addr == `OFS_CTRL) begin
                next_s.rdata = {9'h000, s.wdt_nmi_wake_mask,
                    s.pin_nmi_wake_mask, s.maskable_wake_mask,
                    2'b00, s.standby_request_bit, 1'b0};
            end else if (addr == `OFS_MODE) begin
                next_s.rdata = {15'h0000, s.stop_select_bit};
            end else if (addr == `OFS_CLKSEL) begin
                next_s.rdata = s.clksel;
            end else if (addr == `OFS_STATUS) begin
                next_s.rdata = {13'h0000, s.wake_pend, s.st};
            end else begin
                next_s.rdata = 16'h0000;
            end
        end
        // The CPU is stopped while idle, so writes only land from normal.
        if (wr && s.st == st_normal) begin
            if (addr == `OFS_CTRL) begin
                next_s.standby_request_bit = wdata[`CTRL_STANDBY];
                next_s.maskable_wake_mask = wdata[`CTRL_INT_MASK];
                next_s.pin_nmi_wake_mask = wdata[`CTRL_PIN_NMI_MASK];
                next_s.wdt_nmi_wake_mask = wdata[`CTRL_WDT_NMI_MASK];
            end else if (addr == `OFS_MODE) begin
                next_s.stop_select_bit = wdata[`MODE_STOP_SEL];
            end else if (addr == `OFS_CLKSEL) begin
                next_s.clksel = wdata;
            end
        end
        case (s.st)
            st_normal: begin
                // Stop select must be clear; the deeper mode is not built
                // here, so a request with it set is left standing.
                if (s.standby_request_bit && !s.stop_select_bit) begin
                    next_s.st = st_idle;
                end
            end
            st_idle: begin
                if (wake_any) begin
                    next_s.st = st_wake;
                    next_s.standby_request_bit = 1'b0;
                    if (nmi_wake) begin
                        next_s.ack_nmi = 1'b1;
                    end else if (low_prio) begin
                        next_s.resume_next = 1'b1;
                    end else if (wake_in.int_enabled) begin
                        next_s.ack_maskable = 1'b1;
                    end else begin
                        next_s.resume_next = 1'b1;
                    end
                end
            end
            st_wake: begin
                // Oscillator kept running, so no stabilisation wait.
                next_s.st = st_normal;
            end
            default: begin
                next_s.st = st_normal;
            end
        endcase
        // Set wins over the controller's take in the same cycle.
        if (intc_take || intc_discard) begin
            next_s.wake_pend = 1'b0;
        end
        if (s.st == st_idle && wake_any) begin
            next_s.wake_pend = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_reset) begin
            s <= '{st: st_normal, standby_request_bit: 1'b0,
                maskable_wake_mask: 1'b0, pin_nmi_wake_mask: 1'b0,
                wdt_nmi_wake_mask: 1'b0, stop_select_bit: 1'b0,
                clksel: `CLKSEL_RESET, wake_pend: 1'b0, ack_nmi: 1'b0,
                ack_maskable: 1'b0, resume_next: 1'b0,
                rdata: 16'h0000};
        end else begin
            s <= next_s;
        end
    end

    assign idle = (s.st == st_idle);
    assign clk_en = idle ? idle_en : '1;
    // Pins and state are frozen, not reset, for the whole idle period.
    assign port_hold = idle;
    assign reg_hold = idle;
    assign dac_value_write_en = !idle;
    assign rto_buffer_write_en = !idle;
    assign rdata = s.rdata;
    assign wake_out.ack_nmi = s.ack_nmi;
    assign wake_out.ack_maskable = s.ack_maskable;
    assign wake_out.resume_next = s.resume_next;
    assign wake_out.wake_pending = s.wake_pend;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_reset);

    sequence seq_idle_wake;
        idle && wake_any;
    endsequence

    sequence seq_idle_low_maskable;
        idle && maskable_wake && !nmi_wake && low_prio;
    endsequence

    sequence seq_resume;
        s.st == st_wake ##1 s.st == st_normal && clk_en.cpu;
    endsequence

    AST_WAKE_EXIT: assert property (
        seq_idle_wake |=> seq_resume)
        else $error("Idle not left after a wake request.");

    AST_LOW_PRIO_HELD: assert property (
        seq_idle_low_maskable |=> !wake_out.ack_maskable
            && wake_out.resume_next && wake_out.wake_pending)
        else $error("Lower priority request was acknowledged.");

    AST_HIGH_PRIO_ACK: assert property (
        idle && maskable_wake && !nmi_wake && !low_prio
            && wake_in.int_enabled |=> wake_out.ack_maskable)
        else $error("Higher priority request not acknowledged.");

    AST_NMI_BRANCH: assert property (
        idle && nmi_wake |=> wake_out.ack_nmi && !wake_out.resume_next)
        else $error("NMI wake did not branch to the handler.");

    AST_DI_NEXT: assert property (
        idle && maskable_wake && !nmi_wake && !wake_in.int_enabled
            |=> wake_out.resume_next && !wake_out.ack_maskable)
        else $error("Disabled maskable wake was acknowledged.");

    AST_MASKED_STAYS: assert property (
        idle && s.maskable_wake_mask && s.pin_nmi_wake_mask
            && s.wdt_nmi_wake_mask |=> idle)
        else $error("Masked source ended idle.");

    AST_TIMERS_STOP: assert property (
        idle |-> !clk_en.wide_timer[0] && !clk_en.wide_timer[2]
            && !clk_en.wide_timer[3] && !clk_en.cpu)
        else $error("Stopped timer or CPU clocked in idle.");

    AST_NO_SUB_STOP: assert property (
        idle && !sub_used |-> !clk_en.second_interval_timer
            && !clk_en.second_watchdog)
        else $error("Subclock-only block clocked without subclock.");

    AST_SERIAL_STOP: assert property (
        idle |-> !clk_en.uart[1] && !clk_en.uart[2] && !clk_en.i2c
            && !clk_en.auto_serial)
        else $error("Stopped serial channel clocked in idle.");

    AST_ENTRY: assert property (
        s.st == st_normal && s.standby_request_bit
            && !s.stop_select_bit |=> idle [*2] or
            (idle ##1 s.st == st_wake))
        else $error("Idle not entered after standby request.");

    AST_PEND_HELD: assert property (
        wake_out.wake_pending && !intc_take && !intc_discard
            |=> wake_out.wake_pending)
        else $error("Wake request dropped before acceptance.");

    AST_PORT_HOLD: assert property (
        idle |-> port_hold && reg_hold && !dac_value_write_en)
        else $error("Hold controls released during idle.");

    AST_WIDE_TIMER2: assert property (
        idle |-> clk_en.wide_timer[1] == (s.clksel[`CS_TM1_WT]
            && (sub_used || s.clksel[`CS_WT_MAIN])))
        else $error("Second wide timer gate wrong in idle.");

    AST_NARROW_RUN: assert property (
        idle && !sub_used |-> clk_en.narrow_timer
            == s.clksel[`CS_TM5_EXT+1:`CS_TM5_EXT])
        else $error("Narrow timer gate wrong without subclock.");

    AST_SUB_RUN: assert property (
        idle && sub_used |-> clk_en.second_interval_timer
            == s.clksel[`CS_IH1_SUB]
            && clk_en.second_watchdog == s.clksel[`CS_WDT2_SUB])
        else $error("Subclock block gate wrong in idle.");

    AST_WATCH_RUN: assert property (
        idle |-> clk_en.watch_timer == (sub_used || s.clksel[`CS_WT_MAIN]))
        else $error("Watch timer gate wrong in idle.");

    AST_CSI_EXT: assert property (
        idle |-> clk_en.csi == s.clksel[`CS_CSI_EXT+1:`CS_CSI_EXT])
        else $error("Clocked serial gate wrong in idle.");

    AST_UART0_EXT: assert property (
        idle |-> clk_en.uart[0] == s.clksel[`CS_UART0_EXT])
        else $error("First UART gate wrong in idle.");

    AST_DAC_RUN: assert property (
        idle |-> clk_en.dac && !dac_value_write_en)
        else $error("Converter stopped or writable in idle.");

    AST_RTO_GATE: assert property (
        idle && !clk_en.narrow_timer[s.clksel[`CS_RTO_SEL]]
            |-> !clk_en.rto && !rto_buffer_write_en)
        else $error("Real-time output ran without its timer.");

    AST_REG_FROZEN: assert property (
        idle |=> $stable(s.clksel) && $stable(s.stop_select_bit))
        else $error("Configuration changed during idle.");

    AST_NO_WAIT: assert property (
        s.st == st_wake |=> !idle && clk_en.cpu && clk_en.dma)
        else $error("Resume delayed after wake.");

    AST_WDT_WAKE: assert property (
        idle && wake_in.second_watchdog_irq && !s.wdt_nmi_wake_mask
            && s.clksel[`CS_CPU_ON_SUB] |=> wake_out.ack_nmi)
        else $error("Watchdog request did not wake.");

    AST_GATED_IDLE: assert property (
        idle |-> !clk_en.dma && !clk_en.intc_core && !clk_en.gen_timer
            && !clk_en.first_interval_timer && !clk_en.first_watchdog
            && !clk_en.adc)
        else $error("Gated block clocked in idle.");

    AST_ALL_ON: assert property (
        !idle |-> clk_en == '1)
        else $error("Clock gated outside idle.");

    AST_ONE_ANSWER: assert property (
        $onehot0({wake_out.ack_nmi, wake_out.ack_maskable,
            wake_out.resume_next}))
        else $error("More than one wake answer at once.");

    AST_PEND_SET: assert property (
        seq_idle_wake |=> wake_out.wake_pending)
        else $error("Wake request not latched.");

    // The reset itself is what is checked here, so it may not disable it.
    AST_RESET_CLEAN: assert property (
        disable iff (1'b0) sys_reset |=> !idle && wake_out == '0
            && rdata == 16'h0000)
        else $error("Reset did not return to normal state.");

endmodule

// ==== inc/idle_map.svh ====
// Offsets, field positions, reset values and timing of the idle gate.
// Notes on behaviour
// - Any unmasked request ends idle, any priority; watchdog only with CPU on subclock.
// - Lower priority in service: wake only, keep pending.
// - Higher priority or NMI: wake and acknowledge.
// - NMI wake always branches to handler.
// - Maskable wake: branch if enabled, else next.
// - Source with mask bit set never wakes.
// - Reset during idle is an ordinary reset.
// - First, third, fourth wide timers stop.
// - Second wide timer runs on watch tick only.
// - Narrow timers run on pin clock, or on compare clock with subclock.
// - Second interval timer, watchdog need subclock.
// - Watch timer runs on subclock or main.
// - Clocked serial runs only on external clock.
// - Only first UART on external baud runs.
// - DAC converts, value register not writable.
// - Real-time output needs running narrow timer.
// - Port pins hold level and direction.
// - CPU registers and RAM are preserved.
// - Resume at once, no oscillator wait.
// - Wake sources: pins, peripherals, watchdog, reset.
`ifndef IDLE_MAP_SVH
`define IDLE_MAP_SVH
`define OFS_CTRL 8'h00
`define OFS_MODE 8'h04
`define OFS_CLKSEL 8'h08
`define OFS_STATUS 8'h0c
`define CTRL_STANDBY 1
`define CTRL_INT_MASK 4
`define CTRL_PIN_NMI_MASK 5
`define CTRL_WDT_NMI_MASK 6
`define MODE_STOP_SEL 0
`define CS_SUB_USED 0
`define CS_CPU_ON_SUB 1
`define CS_WT_MAIN 2
`define CS_TM1_WT 3
`define CS_TM5_EXT 4
`define CS_TM5_CMP 6
`define CS_IH1_SUB 8
`define CS_WDT2_SUB 9
`define CS_CSI_EXT 10
`define CS_UART0_EXT 12
`define CS_RTO_EN 13
`define CS_RTO_SEL 14
`define CTRL_RESET 8'h00
`define MODE_RESET 8'h00
`define CLKSEL_RESET 16'h0000
`define RESUME_CYCLES 1
`endif

// ==== inc/idle_pkg.sv ====
// Types shared by the idle gate and its users.
package idle_pkg;
    typedef enum logic [1:0] {
        st_normal = 2'b00,
        st_idle = 2'b01,
        st_wake = 2'b10
    } idle_state_t;

    typedef struct packed {
        logic cpu;
        logic dma;
        logic intc_core;
        logic gen_timer;
        logic [3:0] wide_timer;
        logic [1:0] narrow_timer;
        logic first_interval_timer;
        logic second_interval_timer;
        logic watch_timer;
        logic first_watchdog;
        logic second_watchdog;
        logic [1:0] csi;
        logic auto_serial;
        logic i2c;
        logic [2:0] uart;
        logic adc;
        logic dac;
        logic rto;
    } clk_en_t;

    typedef struct packed {
        logic nmi_pin;
        logic second_watchdog_irq;
        logic [7:0] external_irq_pins;
        logic [7:0] external_irq_enable;
        logic periph_irq;
        logic [2:0] req_prio;
        logic in_isr;
        logic [2:0] isr_prio;
        logic int_enabled;
    } wake_in_t;

    typedef struct packed {
        logic ack_nmi;
        logic ack_maskable;
        logic resume_next;
        logic wake_pending;
    } wake_out_t;
endpackage

// ==== test/intc_model.sv ====
// Interrupt controller stand-in that accepts or drops a latched wake.
module intc_model (
    // Clock and reset.
    input wire logic clock,
    input wire logic reset_n,
    // Latched wake and answer controls.
    input wire logic wake_pending,
    input wire logic [3:0] lag,
    input wire logic drop,
    output logic take,
    output logic discard
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt;
    // A long lag shows whether the latch really holds until answered.
    always_ff @(posedge clock) begin
        take <= 1'b0;
        discard <= 1'b0;
        if (!reset_n || !wake_pending || take || discard) begin
            cnt <= 4'h0;
        end else if (cnt == lag) begin
            take <= !drop;
            discard <= drop;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule

// ==== test/tb.sv ====
// Self-checking bench for the idle gate.
`include "idle_map.svh"
module tb
    import idle_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock, reset_n, wdr, wr, rd, take, discard, drop;
    logic idle, port_hold, reg_hold, dac_we, rto_we;
    logic [7:0] addr;
    logic [15:0] wdata, rdata;
    logic [3:0] lag;
    wake_in_t wi;
    wake_out_t wo;
    clk_en_t clk_en;
    int bad_count = 0;
    int checked = 0;

    idle_mode_wakeup_gating dut_u (.clock(clock), .reset_n(reset_n),
        .second_watchdog_reset(wdr), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .wake_in(wi), .intc_take(take),
        .intc_discard(discard), .wake_out(wo), .clk_en(clk_en),
        .idle(idle), .port_hold(port_hold), .reg_hold(reg_hold),
        .dac_value_write_en(dac_we), .rto_buffer_write_en(rto_we));
    intc_model mdl_u (.clock(clock), .reset_n(reset_n),
        .wake_pending(wo.wake_pending), .lag(lag), .drop(drop),
        .take(take), .discard(discard));

    initial begin
        clock = 1'b0;
        forever #50 clock = !clock;
    end

    task automatic summarize();
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_ce(input clk_en_t got, exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    task automatic bus_rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clock);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask

    // Gates expected in idle, worked out from clock source choices.
    function automatic clk_en_t gate(input logic [15:0] c);
        gate = '0;
        gate.dac = 1'b1;
        gate.watch_timer = c[0] | c[2];
        gate.wide_timer[1] = c[3] & gate.watch_timer;
        gate.narrow_timer = c[5:4] | (c[7:6] & {2{c[0]}});
        gate.second_interval_timer = c[0] & c[8];
        gate.second_watchdog = c[0] & c[9];
        gate.csi = c[11:10];
        gate.uart[0] = c[12];
        gate.rto = c[13] & gate.narrow_timer[c[14]];
    endfunction

    // Fields: nmi, pin, periph, req_prio, in_isr, isr_prio, enabled.
    function automatic wake_in_t mk(input logic [10:0] v);
        mk = '0;
        {mk.nmi_pin, mk.external_irq_pins[0], mk.periph_irq} = v[10:8];
        {mk.req_prio, mk.in_isr, mk.isr_prio, mk.int_enabled} = v[7:0];
        mk.external_irq_enable[0] = 1'b1;
    endfunction

    task automatic enter(input logic [15:0] p);
        int n;
        bus_wr(`OFS_MODE, 16'h0000);
        bus_wr(`OFS_CTRL, p);
        for (n = 0; idle !== 1'b1; n++) begin
            @(posedge clock);
            #1;
            if (n > 8) begin
                bad_count++;
                summarize();
            end
        end
        repeat (5) @(posedge clock);
    endtask

    task automatic stay();
        repeat (4) @(posedge clock);
        #1 chk(16'(idle), 16'h0001);
        @(posedge clock);
    endtask

    task automatic wake(input logic [2:0] e);
        int n;
        for (n = 0; n < 6; n++) begin
            @(posedge clock);
            #1;
            if ({wo.ack_nmi, wo.ack_maskable, wo.resume_next} != 3'b0) break;
        end
        chk(16'({wo.ack_nmi, wo.ack_maskable, wo.resume_next}), 16'(e));
        chk(16'({idle, wo.wake_pending}), 16'h0001);
        if (n == 6) summarize();
        @(posedge clock);
        wi <= '0;
    endtask

    task automatic chk_rst();
        #1 chk_ce(clk_en, '1);
        chk(16'({wo, idle}), 16'h0000);
        bus_rd(`OFS_STATUS, 16'h0000);
        bus_rd(`OFS_CTRL, 16'(`CTRL_RESET));
        bus_rd(`OFS_CLKSEL, `CLKSEL_RESET);
        bus_rd(8'h10, 16'h0000);
    endtask

    task automatic t_gate();
        logic [15:0] cfg [6] = '{16'h0000, 16'h3f39, 16'h000c, 16'h0008,
            16'h60c1, 16'h2000};
        foreach (cfg[i]) begin
            bus_wr(`OFS_CLKSEL, cfg[i]);
            enter(16'h0002);
            chk_ce(clk_en, gate(cfg[i]));
            chk(16'({port_hold, reg_hold, dac_we, rto_we}), 16'hc);
            wi <= mk(11'b1_0_0_000_0_000_0);
            wake(3'b100);
            #1 chk_ce(clk_en, '1);
        end
    endtask

    task automatic t_wake();
        logic [10:0] w [7] = '{11'b1_0_0_000_0_000_0, 11'b0_1_0_000_0_000_1,
            11'b0_1_0_000_0_000_0, 11'b0_0_1_101_1_011_1,
            11'b0_0_1_011_1_011_1, 11'b0_0_1_001_1_011_1,
            11'b1_0_0_111_1_000_1};
        logic [2:0] e [7] = '{3'b100, 3'b010, 3'b001, 3'b001, 3'b001,
            3'b010, 3'b100};
        int n;
        lag <= 4'h8;
        foreach (w[i]) begin
            drop <= i[0];
            enter(16'h0002);
            wi <= mk(w[i]);
            wake(e[i]);
            repeat (3) @(posedge clock);
            #1 chk(16'(wo.wake_pending), 16'h0001);
            for (n = 0; wo.wake_pending === 1'b1 && n < 20; n++) begin
                @(posedge clock);
                #1;
            end
            chk(16'(wo.wake_pending), 16'h0000);
        end
    endtask

    task automatic t_mask();
        lag <= 4'h0;
        bus_wr(`OFS_MODE, 16'h0001);
        bus_wr(`OFS_CTRL, 16'h0002);
        repeat (3) @(posedge clock);
        #1 chk(16'(idle), 16'h0000);
        bus_wr(`OFS_CTRL, 16'h0000);
        enter(16'h0022);
        wi <= mk(11'b1_0_0_000_0_000_0);
        stay();
        wi.second_watchdog_irq <= 1'b1;
        stay();
        bus_wr(`OFS_CLKSEL, 16'hffff);
        wi <= mk(11'b0_0_1_000_0_000_1);
        wake(3'b010);
        bus_rd(`OFS_CLKSEL, 16'h2000);
        enter(16'h0012);
        wi <= mk(11'b0_0_1_000_0_000_1);
        stay();
        wi <= mk(11'b1_0_0_000_0_000_0);
        wake(3'b100);
        bus_wr(`OFS_CLKSEL, 16'h0002);
        enter(16'h0002);
        wi.second_watchdog_irq <= 1'b1;
        wake(3'b100);
        enter(16'h0042);
        wi.second_watchdog_irq <= 1'b1;
        stay();
        wdr <= 1'b1;
        @(posedge clock);
        wdr <= 1'b0;
        wi <= '0;
        chk_rst();
    endtask

    initial begin
        {reset_n, wdr, wr, rd, drop} = '0;
        addr = 8'h00;
        wdata = 16'h0000;
        lag = 4'h0;
        wi = '0;
        repeat (4) @(posedge clock);
        reset_n <= 1'b1;
        chk_rst();
        t_gate();
        t_wake();
        t_mask();
        summarize();
    end
endmodule
